// >>> core/acl_map.svh
// Constants for the converter read/convert and latchup status block
// Summary of operation
// - CS low, read/convert falling, busy low: drive previous result, conversion continues.
// - CS and read/convert low as busy rises: reconvert without new sample, invalid.
// - While busy low, all new convert requests are ignored.
// - Overcurrent detected: switch core power off, then back on.
// - Status high after overcurrent with power removed; low while core powered.
// - Result always one 16-bit word on data 15:0, bit 15 MSB.
// - CS high keeps the data bus high impedance.
// - Convert request while busy high starts a conversion, bus stays off.
// - Busy rising with CS low and read/convert high puts new result out.
// - Each result is a 16-bit two's complement parallel word.
`ifndef ACL_MAP_SVH
`define ACL_MAP_SVH
`define ACL_CLK_NS 20
`define ACL_CONV_NS 8000
`define ACL_CONV_CYC ((`ACL_CONV_NS) / (`ACL_CLK_NS))
`define ACL_PT_NS 1000
`define ACL_PT_CYC ((`ACL_PT_NS) / (`ACL_CLK_NS))
`define ACL_DATA_W 16
`define ACL_CNT_W 10
`endif

// >>> core/acl_pkg.sv
// Types for the converter read/convert and latchup status block
package acl_pkg;
    typedef enum logic [2:0] {
        ACL_IDLE = 3'b001,
        ACL_CONV = 3'b010,
        ACL_OFF = 3'b100
    } acl_state_t;
endpackage : acl_pkg

// >>> core/acl_conv_ctrl.sv
// Converter control: read/convert handshake, result bus, latchup power cycle
`timescale 1ns/1ns
`default_nettype none
`include "acl_map.svh"
module acl_conv_ctrl
    import acl_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic CS_N,
    input wire logic RD_CONV,
    input wire logic OVERCURRENT,
    input wire logic [15:0] SAMPLE,
    output logic BUSY,
    output logic [15:0] DATA_O,
    output logic DATA_OE,
    output logic STATUS,
    output logic CORE_PWR,
    output logic RESULT_VALID
);
    localparam logic [9:0] CONV_CYC = 10'(`ACL_CONV_CYC);
    localparam logic [9:0] PT_CYC = 10'(`ACL_PT_CYC);

    logic [1:0] cs_s_q, rc_s_q, oc_s_q;
    logic [9:0] off_run_q;
    logic cs_n, rc, oc, rc_prev_q;
    acl_state_t state_q;
    logic [9:0] cnt_q;
    logic [15:0] cur_q, prev_q;
    logic cur_ok_q, prev_ok_q, samp_q;
    logic rc_fall, start, done;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            cs_s_q <= 2'h3;
            rc_s_q <= 2'h3;
            oc_s_q <= 2'h0;
        end else begin
            cs_s_q <= {cs_s_q[0], CS_N};
            rc_s_q <= {rc_s_q[0], RD_CONV};
            oc_s_q <= {oc_s_q[0], OVERCURRENT};
        end
    end
    assign cs_n = cs_s_q[1];
    assign rc = rc_s_q[1];
    assign oc = oc_s_q[1];

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            rc_prev_q <= 1'b1;
        end else begin
            rc_prev_q <= rc;
        end
    end
    assign rc_fall = rc_prev_q && !rc;
    // Busy high means idle; requests while converting are dropped
    assign start = (state_q == ACL_IDLE) && !cs_n && rc_fall;
    assign done = (state_q == ACL_CONV) && (cnt_q == 10'h0);

    ////////////////////////////////////////////////////////////////////
    // Conversion and power sequencing
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            state_q <= ACL_IDLE;
            cnt_q <= 10'h0;
            samp_q <= 1'b0;
        end else if (oc && state_q != ACL_OFF) begin
            state_q <= ACL_OFF;
            cnt_q <= PT_CYC - 10'h1;
        end else begin
            unique case (state_q)
                ACL_IDLE: begin
                    if (start) begin
                        state_q <= ACL_CONV;
                        cnt_q <= CONV_CYC - 10'h1;
                        samp_q <= 1'b1;
                    end
                end
                ACL_CONV: begin
                    // edges on the pins are not looked at here
                    if (done) begin
                        if (!cs_n && !rc) begin
                            cnt_q <= CONV_CYC - 10'h1;
                            samp_q <= 1'b0;
                        end else begin
                            state_q <= ACL_IDLE;
                        end
                    end else begin
                        cnt_q <= cnt_q - 10'h1;
                    end
                end
                ACL_OFF: begin
                    if (cnt_q == 10'h0) begin
                        state_q <= ACL_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 10'h1;
                    end
                end
                default: state_q <= ACL_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Result registers, two's complement word taken at conversion start
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            cur_q <= 16'h0;
            prev_q <= 16'h0;
            cur_ok_q <= 1'b0;
            prev_ok_q <= 1'b0;
        end else if (state_q == ACL_OFF) begin
            cur_ok_q <= 1'b0;
            prev_ok_q <= 1'b0;
        end else if (start) begin
            prev_q <= cur_q;
            prev_ok_q <= cur_ok_q;
            cur_q <= SAMPLE;
            cur_ok_q <= 1'b1;
        end else if (done && !cs_n && !rc) begin
            cur_ok_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            BUSY <= 1'b1;
            DATA_O <= 16'h0;
            DATA_OE <= 1'b0;
            STATUS <= 1'b0;
            CORE_PWR <= 1'b1;
            RESULT_VALID <= 1'b0;
        end else begin
            BUSY <= (state_q == ACL_IDLE) && !start;
            STATUS <= (state_q == ACL_OFF);
            CORE_PWR <= (state_q != ACL_OFF);
            if (cs_n || state_q == ACL_OFF || start) begin
                DATA_OE <= 1'b0;
            end else if (state_q == ACL_CONV && !rc) begin
                DATA_OE <= 1'b1;
                DATA_O <= prev_q;
                RESULT_VALID <= prev_ok_q;
            end else if (state_q == ACL_IDLE && rc) begin
                DATA_OE <= 1'b1;
                DATA_O <= cur_q;
                RESULT_VALID <= cur_ok_q && samp_q;
            end else begin
                DATA_OE <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Length of the current power-off stretch, read only by the checks
    always_ff @(posedge SYS_CLK) begin
        if (RESET || state_q != ACL_OFF) begin
            off_run_q <= 10'h0;
        end else begin
            off_run_q <= off_run_q + 10'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    cs_high_hiz_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        cs_n |=> !DATA_OE) else $error("bus driven with chip select high");
    start_busy_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        start |=> !BUSY && !DATA_OE) else $error("start did not drop busy");
    ignore_req_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (state_q == ACL_CONV && !done && !oc) |=> state_q == ACL_CONV)
        else $error("conversion interrupted");
    conv_len_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (start && !oc) ##1 (!oc)[*8] |-> state_q == ACL_CONV)
        else $error("conversion too short");
    status_off_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        STATUS |-> !CORE_PWR && !DATA_OE) else $error("status with power on");
    oc_trip_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (oc && state_q != ACL_OFF) |=> ##1 STATUS) else $error("no power cut");
    pwr_back_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        $rose(STATUS) |-> ##[1:60] !STATUS) else $error("power not restored");
    prev_read_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (state_q == ACL_CONV && !cs_n && !rc && !oc) |=> DATA_OE && DATA_O == $past(prev_q))
        else $error("previous result not driven");
    new_read_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (state_q == ACL_IDLE && !cs_n && rc && !oc) |=> DATA_OE && DATA_O == $past(cur_q))
        else $error("new result not driven");
    status_low_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (state_q != ACL_OFF) |=> !STATUS && CORE_PWR) else $error("status with power on");
    reconv_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (done && !cs_n && !rc && !oc) |=> state_q == ACL_CONV && !cur_ok_q)
        else $error("reconversion not started");
    busy_low_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (state_q == ACL_CONV) |=> !BUSY) else $error("busy high while converting");
    refused_req_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (state_q == ACL_CONV && rc_fall && !done && !oc) |=> $stable(cur_q) && $stable(prev_q))
        else $error("request taken while converting");
    sample_take_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        start |=> cur_q == $past(SAMPLE)) else $error("sample not taken at start");
    off_len_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        off_run_q <= PT_CYC) else $error("power held off too long");
    // Main scenarios: plain conversion, reconversion, trip, both kinds of read
    cov_conv_c: cover property (@(posedge SYS_CLK) start ##[1:500] done);
    cov_prev_c: cover property (@(posedge SYS_CLK) state_q == ACL_CONV && DATA_OE);
    cov_new_c: cover property (@(posedge SYS_CLK) state_q == ACL_IDLE && DATA_OE);
    cov_reconv_c: cover property (@(posedge SYS_CLK) done && !cs_n && !rc);
    cov_trip_c: cover property (@(posedge SYS_CLK) $rose(STATUS));
endmodule : acl_conv_ctrl
`default_nettype wire

// >>> tb/acl_host_model.sv
// Host-side model that drives the converter control lines
`timescale 1ns/1ns
`default_nettype none
module acl_host_model (
    input wire logic STATUS,
    input wire logic CS_N_REQ,
    input wire logic RD_CONV_REQ,
    output logic CS_N,
    output logic RD_CONV
);
    // Lines pulled low at once while core power is removed
    assign CS_N = STATUS ? 1'b0 : CS_N_REQ;
    assign RD_CONV = STATUS ? 1'b0 : RD_CONV_REQ;
endmodule : acl_host_model
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic sys_clk, reset, cs_req, rd_req, ovc;
    logic [15:0] sample;
    wire logic cs_n, rd_conv, busy, oe, status, pwr, vld;
    wire logic [15:0] data;
    int bad_count = 0;
    int n_checks = 0;
    int n;
    acl_host_model HOST (.STATUS(status), .CS_N_REQ(cs_req), .RD_CONV_REQ(rd_req),
        .CS_N(cs_n), .RD_CONV(rd_conv));
    acl_conv_ctrl DUT (.SYS_CLK(sys_clk), .RESET(reset), .CS_N(cs_n),
        .RD_CONV(rd_conv), .OVERCURRENT(ovc), .SAMPLE(sample), .BUSY(busy),
        .DATA_O(data), .DATA_OE(oe), .STATUS(status), .CORE_PWR(pwr),
        .RESULT_VALID(vld));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #2;
    endtask : tick
    task automatic wait_for(input bit on_status, input logic v, output int c);
        c = 0;
        while (((on_status ? status : busy) !== v) && c < 600) begin
            tick(1);
            c++;
        end
        if (c >= 600) begin
            bad_count++;
            wrap_up();
        end
    endtask : wait_for
    task automatic wrap_up();
        if (bad_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        reset = 1'b1;
        cs_req = 1'b1;
        rd_req = 1'b1;
        ovc = 1'b0;
        sample = 16'h8001;
        tick(16);
        reset = 1'b0;
        tick(2);
        chk({11'h000, busy, oe, status, pwr, vld}, 16'h0012);
        cs_req = 1'b0;
        rd_req = 1'b0;
        tick(3);
        rd_req = 1'b1;
        wait_for(1'b0, 1'b0, n);
        tick(3);
        chk(16'(oe), 16'h0000);
        // Read during conversion doubles as a refused convert request
        rd_req = 1'b0;
        tick(4);
        chk({15'h0000, oe}, 16'h0001);
        chk(data, 16'h0000);
        rd_req = 1'b1;
        wait_for(1'b0, 1'b1, n);
        chk(16'(n < 400), 16'h0001);
        tick(3);
        chk({14'h0000, oe, vld}, 16'h0003);
        chk(data, 16'h8001);
        cs_req = 1'b1;
        tick(4);
        chk(16'(oe), 16'h0000);
        // Lines held low across the end of conversion on purpose
        sample = 16'h1234;
        cs_req = 1'b0;
        rd_req = 1'b0;
        wait_for(1'b0, 1'b0, n);
        tick(420);
        chk(16'(busy), 16'h0000);
        rd_req = 1'b1;
        wait_for(1'b0, 1'b1, n);
        tick(3);
        chk(16'(vld), 16'h0000);
        cs_req = 1'b1;
        ovc = 1'b1;
        wait_for(1'b1, 1'b1, n);
        ovc = 1'b0;
        chk({14'h0000, pwr, oe}, 16'h0000);
        wait_for(1'b1, 1'b0, n);
        chk(16'(pwr), 16'h0001);
        chk(16'(n > 40 && n < 60), 16'h0001);
        // Word read right after the power cycle is flagged as not valid
        cs_req = 1'b0;
        tick(4);
        chk({14'h0000, oe, vld}, 16'h0002);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
